// ---- hdl/watchdog_defines.svh ----
// Constants for the key-protected watchdog: offsets, fields, reset values.
// Assumes inclusion by bare name from the watchdog design files.
`ifndef WATCHDOG_DEFINES_SVH
`define WATCHDOG_DEFINES_SVH
`define WD_OFS_CONTROL 8'h00
`define WD_OFS_RESTART 8'h04
`define WD_CONTROL_RESET 32'h00000000
`define WD_EN_BIT 0
`define WD_PSEL_LSB 8
`define WD_PSEL_MSB 12
`define WD_KEY_LSB 24
`define WD_KEY_MSB 31
`define WD_KEY_FIRST 8'h55
`define WD_KEY_SECOND 8'hAA
`define WD_CONTROL_RW_MASK 32'h00001F01
`define WD_RESET_PULSE_CYCLES 8'h10
`endif

// ---- hdl/watchdog_pkg.sv ----
// Types shared by the watchdog design files.
// Assumes nothing of its surroundings.
package watchdog_pkg;
  typedef enum logic [1:0] {
    KEY_IDLE = 2'b00,
    KEY_ARMED = 2'b01
  } key_state_e;
  typedef logic [31:0] word_t;
endpackage

// ---- hdl/watchdog_prescaler.sv ----
// Prescaler counter of the watchdog with its timeout tap.
// Assumes a single clock; the rc tick enable marks oscillator edges.
`timescale 1ns/1ps
`default_nettype none
module watchdog_prescaler
  import watchdog_pkg::*;
#(
  parameter int WIDTH = 32
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run,
  input wire logic tick,
  input wire logic clear,
  input wire logic [4:0] psel,
  output logic expire
);
  logic [WIDTH-1:0] count_reg;
  logic [WIDTH:0] tap_mask;
  logic hit;

  // The tap is the tick that would carry into bit psel+1 of the count, so expiry comes after 2^(psel+1) ticks.
  // The shift amount is six bits wide so that a select of 31 reaches 2^32, not zero.
  assign tap_mask = ({{WIDTH{1'b0}}, 1'b1} << ({1'b0, psel} + 6'h01)) - {{WIDTH{1'b0}}, 1'b1};
  assign hit = run && tick && ({1'b0, count_reg} == tap_mask);

  // Clear restarts from zero; expiry also wraps so the next period starts at once.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      count_reg <= '0;
    else if (clear || hit)
      count_reg <= '0;
    else if (run && tick)
      count_reg <= count_reg + {{(WIDTH-1){1'b0}}, 1'b1};
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      expire <= 1'b0;
    else
      expire <= hit;
  end
endmodule
`default_nettype wire

// ---- hdl/watchdog_key_protected.sv ----
// Key-protected watchdog with an AXI4-Lite register slave.
// Assumes rc_tick is a one-cycle enable at each rising oscillator edge.
`timescale 1ns/1ps
`default_nettype none
`include "watchdog_defines.svh"
module watchdog_key_protected
  import watchdog_pkg::*;
#(
  parameter int PRESCALER_WIDTH = 32
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic rc_tick,
  input wire logic debug_halt,
  input wire logic debug_keep_running,
  input wire logic sleep_static_req,
  output logic rc_oscillator_enable,
  output logic soft_reset,
  output logic enter_shutdown,
  output logic enter_static
);
  word_t control_reg;
  word_t control_next;
  key_state_e key_state_reg;
  key_state_e key_state_next;
  word_t armed_bits_reg;
  logic aw_held_reg;
  logic w_held_reg;
  logic [7:0] awaddr_reg;
  word_t wdata_reg;
  logic [3:0] wstrb_reg;
  logic [7:0] pulse_count_reg;
  logic write_fire;
  logic hit_control;
  logic hit_restart;
  logic full_word;
  logic [7:0] key_in;
  word_t payload_in;
  logic unlock_ok;
  logic restart_fire;
  logic enabled;
  logic prescaler_run;
  logic expire;
  logic read_fire;
  logic read_mapped;
  word_t read_value;
  logic read_hit_control;

  // Decode compares word indices only; the two low address bits are ignored.
  // A byte-offset access therefore lands on the word that holds it.
  function automatic logic addr_hits(input logic [7:0] addr, input logic [7:0] offset);
    return addr[7:2] == offset[7:2];
  endfunction

  // A write is executed once address and data have both been taken.
  assign write_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign hit_control = addr_hits(awaddr_reg, `WD_OFS_CONTROL);
  assign hit_restart = addr_hits(awaddr_reg, `WD_OFS_RESTART);
  assign full_word = wstrb_reg == 4'hF;
  assign key_in = wdata_reg[`WD_KEY_MSB:`WD_KEY_LSB];
  assign payload_in = wdata_reg & `WD_CONTROL_RW_MASK;

  // Partial-strobe writes to control never unlock it: the key needs the whole word.
  assign unlock_ok = write_fire && hit_control && full_word && key_state_reg == KEY_ARMED &&
                     key_in == `WD_KEY_SECOND && payload_in == armed_bits_reg;
  assign control_next = unlock_ok ? payload_in : control_reg;
  assign restart_fire = write_fire && hit_restart;
  assign enabled = control_reg[`WD_EN_BIT];
  assign prescaler_run = enabled && !(debug_halt && !debug_keep_running);

  // Key sequencing: a full-word first key arms or re-arms; any other control write drops back to idle.
  always_comb
  begin
    key_state_next = key_state_reg;
    if (write_fire && hit_control)
    begin
      if (full_word && key_state_reg == KEY_IDLE && key_in == `WD_KEY_FIRST)
        key_state_next = KEY_ARMED;
      else if (full_word && key_state_reg == KEY_ARMED && key_in == `WD_KEY_FIRST)
        key_state_next = KEY_ARMED;
      else
        key_state_next = KEY_IDLE;
    end
  end

  // Control, key state and the armed copy of the first write's bits.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      control_reg <= `WD_CONTROL_RESET;
      key_state_reg <= KEY_IDLE;
      armed_bits_reg <= '0;
    end
    else
    begin
      control_reg <= control_next;
      key_state_reg <= key_state_next;
      if (write_fire && hit_control && key_in == `WD_KEY_FIRST)
        armed_bits_reg <= payload_in;
    end
  end

  // Write address and data channels are taken independently, in either order.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= '0;
      wstrb_reg <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      else if (write_fire)
        aw_held_reg <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      else if (write_fire)
        w_held_reg <= 1'b0;
    end
  end

  // Ready outputs are registered; each drops once its item is held.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end
    else
    begin
      s_axi_awready <= !aw_held_reg && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready <= !w_held_reg && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
    end
  end

  // Unmapped addresses answer DECERR on both channels.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end
    else if (write_fire)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (hit_control || hit_restart) ? 2'b00 : 2'b11;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // Reads: key bits and the restart register always return zero.
  assign read_fire = s_axi_arvalid && s_axi_arready;
  assign read_hit_control = addr_hits(s_axi_araddr, `WD_OFS_CONTROL);
  assign read_mapped = read_hit_control || addr_hits(s_axi_araddr, `WD_OFS_RESTART);
  assign read_value = read_hit_control ?
                      (control_reg & `WD_CONTROL_RW_MASK) : 32'h00000000;

  // Read data are latched at the address handshake, so rdata stands with rvalid.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= 2'b00;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !read_fire;
      if (read_fire)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= read_value;
        s_axi_rresp <= read_mapped ? 2'b00 : 2'b11;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // The count is held at zero while disabled, so enabling starts a full period.
  watchdog_prescaler #(
    .WIDTH(PRESCALER_WIDTH)
  ) watchdog_prescaler_i (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(prescaler_run),
    .tick(rc_tick),
    .clear(restart_fire || !enabled),
    .psel(control_reg[`WD_PSEL_MSB:`WD_PSEL_LSB]),
    .expire(expire)
  );

  // Soft reset is stretched to a fixed pulse; the prescaler keeps counting meanwhile.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pulse_count_reg <= 8'h00;
      soft_reset <= 1'b0;
    end
    else
    begin
      if (expire)
        pulse_count_reg <= `WD_RESET_PULSE_CYCLES;
      else if (pulse_count_reg != 8'h00)
        pulse_count_reg <= pulse_count_reg - 8'h01;
      soft_reset <= expire || pulse_count_reg > 8'h01;
    end
  end

  // Sleep steering: an enabled watchdog keeps its oscillator and forbids static sleep.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rc_oscillator_enable <= 1'b0;
      enter_shutdown <= 1'b0;
      enter_static <= 1'b0;
    end
    else
    begin
      rc_oscillator_enable <= control_next[`WD_EN_BIT];
      enter_shutdown <= sleep_static_req && control_next[`WD_EN_BIT];
      enter_static <= sleep_static_req && !control_next[`WD_EN_BIT];
    end
  end

  // Checks on the key sequence, the read path, the soft reset and the sleep steering.
  a_bad_key_holds: assert property (@(posedge aclk) disable iff (!aresetn)
    (write_fire && hit_control && !unlock_ok) |=> $stable(control_reg))
    else $error("control changed without unlock");
  a_key_reads_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid |-> s_axi_rdata[31:24] == 8'h00)
    else $error("key field read nonzero");
  a_osc_follows_en: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 rc_oscillator_enable == $past(control_next[0]))
    else $error("oscillator enable mismatch");
  a_static_blocked: assert property (@(posedge aclk) disable iff (!aresetn)
    enabled ##1 enabled |-> !enter_static)
    else $error("static entered while enabled");
  a_stop_no_expire: assert property (@(posedge aclk) disable iff (!aresetn)
    !prescaler_run |=> !expire)
    else $error("expiry while stopped");
  a_expire_resets: assert property (@(posedge aclk) disable iff (!aresetn)
    expire |=> soft_reset [*8])
    else $error("soft reset pulse too short");
  a_restart_no_exp: assert property (@(posedge aclk) disable iff (!aresetn)
    restart_fire |=> !expire [*2])
    else $error("expiry right after restart");
  a_shutdown_when_en: assert property (@(posedge aclk) disable iff (!aresetn)
    (sleep_static_req && enabled) ##1 enabled |-> enter_shutdown)
    else $error("shutdown not entered");

  // Further checks: committed enable, partial writes, pulse shape and steering levels.
  a_unlock_enables: assert property (@(posedge aclk) disable iff (!aresetn)
    unlock_ok |=> enabled == $past(payload_in[`WD_EN_BIT]))
    else $error("enable bit not committed");
  a_partial_drops: assert property (@(posedge aclk) disable iff (!aresetn)
    (write_fire && hit_control && !full_word) |=> key_state_reg == KEY_IDLE)
    else $error("partial write kept key armed");
  a_restart_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    (read_fire && addr_hits(s_axi_araddr, `WD_OFS_RESTART)) |=> s_axi_rdata == 32'h00000000)
    else $error("restart register read nonzero");
  a_pulse_start: assert property (@(posedge aclk) disable iff (!aresetn)
    expire |=> soft_reset && pulse_count_reg == `WD_RESET_PULSE_CYCLES)
    else $error("soft reset pulse did not start");
  a_pulse_counts: assert property (@(posedge aclk) disable iff (!aresetn)
    (pulse_count_reg != 8'h00 && !expire) |=> pulse_count_reg == $past(pulse_count_reg) - 8'h01)
    else $error("soft reset counter skipped");
  a_expire_run: assert property (@(posedge aclk) disable iff (!aresetn)
    expire |-> $past(prescaler_run))
    else $error("expiry without running prescaler");
  a_osc_tracks_en: assert property (@(posedge aclk) disable iff (!aresetn)
    rc_oscillator_enable == enabled)
    else $error("oscillator enable differs from enable bit");
  a_shutdown_needs_en: assert property (@(posedge aclk) disable iff (!aresetn)
    enter_shutdown |-> enabled)
    else $error("shutdown while disabled");
  a_static_when_off: assert property (@(posedge aclk) disable iff (!aresetn)
    (sleep_static_req && !enabled) ##1 !enabled |-> enter_static)
    else $error("static sleep not entered");

  // Coverage of the main scenarios.
  c_unlock: cover property (@(posedge aclk) unlock_ok);
  c_bad_key: cover property (@(posedge aclk) write_fire && hit_control && !unlock_ok);
  c_expire: cover property (@(posedge aclk) expire);
  c_restart: cover property (@(posedge aclk) restart_fire && enabled);
  c_shutdown: cover property (@(posedge aclk) enter_shutdown);
endmodule
`default_nettype wire

// ---- test/watchdog_key_protected_tb.sv ----
// Self-checking bench for the key-protected watchdog: bus, timeout, debug and sleep steering.
// Assumes the design files are compiled first; the bench drives every port itself.
`timescale 1ns/1ps
`default_nettype none
`include "watchdog_defines.svh"
module watchdog_key_protected_tb
  import watchdog_pkg::*;
;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  word_t s_axi_wdata = 32'h00000000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic rc_tick = 1'b0, debug_halt = 1'b0, debug_keep_running = 1'b0, sleep_static_req = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  word_t s_axi_rdata, rd_mask;
  logic rc_oscillator_enable, soft_reset, enter_shutdown, enter_static;
  logic [33:0] rd_exp;
  int failures = 0, checked = 0, cycles = 0;
  word_t seed = 32'h7E59B05F;
  logic [1:0] exp_b[$];
  logic [33:0] exp_r[$];
  word_t exp_m[$];

  watchdog_key_protected watchdog_key_protected_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rc_tick, .debug_halt, .debug_keep_running,
    .sleep_static_req, .rc_oscillator_enable, .soft_reset, .enter_shutdown, .enter_static);

  // The clock toggles every 2.5 ns, a period of 5 ns.
  always #2.5 aclk = ~aclk;

  function automatic word_t xorshift(input word_t v);
    word_t x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  function automatic word_t ctrl(input logic [7:0] key, input logic [4:0] psel, input logic en);
    return {key, 11'h000, psel, 7'h00, en};
  endfunction

  task automatic cmp_word(input word_t got, input word_t exp);
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
    cmp_word({31'h00000000, got}, {31'h00000000, exp});
  endtask

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // A hang is cut short well beyond the few hundred cycles the run needs.
  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      end_sim();
    end
  end

  // Responses are taken at the edge where valid and ready meet and matched to the oldest note.
  always @(posedge aclk)
  begin
    if (aresetn && s_axi_bvalid && s_axi_bready)
      cmp_word({30'h00000000, s_axi_bresp}, {30'h00000000, exp_b.pop_front()});
    if (aresetn && s_axi_rvalid && s_axi_rready)
    begin
      rd_exp = exp_r.pop_front();
      rd_mask = exp_m.pop_front();
      cmp_word({30'h00000000, s_axi_rresp}, {30'h00000000, rd_exp[33:32]});
      cmp_word(s_axi_rdata & rd_mask, rd_exp[31:0]);
    end
  end

  // Address and data go out together; each drops once taken, and the task returns on bvalid.
  task automatic axi_write(input logic [7:0] a, input word_t d, input logic [3:0] s,
                           input logic [1:0] resp);
    exp_b.push_back(resp);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
  endtask

  // Unmapped reads give no defined data, so the mask hides it there.
  task automatic axi_read(input logic [7:0] a, input word_t d, input word_t m,
                          input logic [1:0] resp);
    exp_r.push_back({resp, d});
    exp_m.push_back(m);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
  endtask

  task automatic ticks(input int n);
    repeat (n)
    begin
      rc_tick <= 1'b1;
      @(posedge aclk);
      rc_tick <= 1'b0;
      repeat (3) @(posedge aclk);
    end
  endtask

  // Random noise in the unused bits is kept identical across the pair.
  task automatic unlock(input logic [4:0] p, input logic e);
    word_t noise;
    noise = seed & 32'h00FFE0FE;
    seed = xorshift(seed);
    axi_write(8'h00, ctrl(8'h55, p, e) | noise, 4'hF, 2'b00);
    axi_write(8'h00, ctrl(8'hAA, p, e) | noise, 4'hF, 2'b00);
  endtask

  task automatic restart();
    axi_write(8'h04, seed, 4'hF, 2'b00);
    seed = xorshift(seed);
  endtask

  // The last tick of a period is sent here so that the whole pulse is seen.
  task automatic expire_tick();
    int n;
    rc_tick <= 1'b1;
    @(posedge aclk);
    rc_tick <= 1'b0;
    n = 0;
    while (soft_reset !== 1'b1 && n < 8)
    begin
      @(posedge aclk);
      n++;
    end
    cmp_bit(soft_reset, 1'b1);
    n = 0;
    while (soft_reset === 1'b1 && n < 40)
    begin
      @(posedge aclk);
      n++;
    end
    cmp_word(word_t'(n), 32'h00000010);
  endtask

  // Main sequence: with a prescale select of one, a period is four oscillator ticks.
  initial
  begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    cmp_bit(rc_oscillator_enable, 1'b0);
    axi_read(8'h00, 32'h00000000, 32'hFFFFFFFF, 2'b00);
    axi_read(8'h04, 32'h00000000, 32'hFFFFFFFF, 2'b00);
    axi_read(8'h08, 32'h00000000, 32'h00000000, 2'b11);
    axi_write(8'h08, seed, 4'hF, 2'b11);
    // A period of four ticks is still longer than the bench's own start-up.
    unlock(5'h01, 1'b1);
    axi_read(8'h00, ctrl(8'h00, 5'h01, 1'b1), 32'hFFFFFFFF, 2'b00);
    cmp_bit(rc_oscillator_enable, 1'b1);
    axi_write(8'h00, ctrl(8'h55, 5'h03, 1'b0), 4'hF, 2'b00);
    axi_write(8'h00, ctrl(8'hAA, 5'h02, 1'b0), 4'hF, 2'b00);
    axi_write(8'h00, ctrl(8'hAA, 5'h03, 1'b0), 4'hF, 2'b00);
    axi_write(8'h00, ctrl(8'h55, 5'h03, 1'b0), 4'hF, 2'b00);
    axi_write(8'h00, ctrl(8'hAA, 5'h03, 1'b0), 4'h7, 2'b00);
    axi_read(8'h00, ctrl(8'h00, 5'h01, 1'b1), 32'hFFFFFFFF, 2'b00);
    restart();
    repeat (3)
    begin
      ticks(3);
      restart();
      cmp_bit(soft_reset, 1'b0);
    end
    ticks(3);
    cmp_bit(soft_reset, 1'b0);
    expire_tick();
    ticks(3);
    cmp_bit(soft_reset, 1'b0);
    expire_tick();
    restart();
    debug_halt <= 1'b1;
    ticks(8);
    cmp_bit(soft_reset, 1'b0);
    debug_keep_running <= 1'b1;
    ticks(3);
    expire_tick();
    debug_halt <= 1'b0;
    debug_keep_running <= 1'b0;
    sleep_static_req <= 1'b1;
    repeat (3) @(posedge aclk);
    cmp_bit(enter_shutdown, 1'b1);
    cmp_bit(enter_static, 1'b0);
    unlock(5'h00, 1'b0);
    repeat (2) @(posedge aclk);
    cmp_bit(enter_static, 1'b1);
    cmp_bit(enter_shutdown, 1'b0);
    cmp_bit(rc_oscillator_enable, 1'b0);
    ticks(8);
    cmp_bit(soft_reset, 1'b0);
    end_sim();
  end
endmodule
`default_nettype wire
